// ---- rtl/msc_pkg.sv ----
// shared constants, types and register map of the meter settings control block
package msc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  localparam int unsigned HELP_MS = 3000;
  localparam int unsigned HELP_CYC = CLK_KHZ * HELP_MS;
  localparam int unsigned UPD_MS = 250;
  localparam int unsigned UPD_CYC = CLK_KHZ * UPD_MS;
  localparam int unsigned CTL_RESP_MS = 25;
  localparam int unsigned CTL_RESP_CYC = CLK_KHZ * CTL_RESP_MS;
  localparam int unsigned TMR_W = 26;

  ////////////////////////////////////////////////////////////////////////////
  // value ranges
  localparam int unsigned VAL_W = 17;
  localparam logic [16:0] VAL_MAX = 17'h1869F;
  localparam logic [16:0] SMIN_RST = 17'h00000;
  localparam logic [16:0] SMAX_RST = 17'h00064;
  localparam logic [16:0] HALARM_RST = 17'h003E8;
  localparam logic [6:0] NODE_MIN = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h63;
  localparam logic [6:0] NODE_RST = 7'h01;
  localparam int unsigned RETX_W = 8;
  localparam logic [7:0] RETX_TOP = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_SMIN = 8'h04;
  localparam logic [7:0] OFS_SMAX = 8'h08;
  localparam logic [7:0] OFS_NODE = 8'h0C;
  localparam logic [7:0] OFS_HALARM = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // serial character format reported in the status word
  localparam logic [2:0] FMT_DATA_BITS = 3'h7;
  localparam logic FMT_PARITY_EVEN = 1'b1;
  localparam logic FMT_STOP_BITS = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    RETX_NONE = 3'h0, RETX_0_5V = 3'h1, RETX_0_10V = 3'h2, RETX_0_20MA = 3'h3, RETX_4_20MA = 3'h4
  } msc_retx_e;
  typedef enum logic [1:0] {
    BAUD_1200 = 2'h0, BAUD_2400 = 2'h1, BAUD_4800 = 2'h2, BAUD_9600 = 2'h3
  } msc_baud_e;
  typedef enum logic [1:0] {
    COL_RED = 2'h0, COL_GREEN = 2'h1, COL_GREEN_TO_RED = 2'h2, COL_RED_THEN_GREEN = 2'h3
  } msc_colour_e;
  typedef enum logic [1:0] {PR_NAME = 2'b01, PR_VALUE = 2'b10} msc_prompt_e;

  typedef struct packed {
    logic prompt_text_setting;
    logic preset_lock;
    msc_colour_e colour;
    msc_baud_e baud;
    logic serial_fitted;
    msc_retx_e retx_sel;
    logic reset_key_en;
  } msc_cfg_s;
  localparam int unsigned CFG_W = 11;
  localparam logic [10:0] CFG_RST = 11'h541;

  typedef struct packed {
    logic rst;
    logic down;
    logic scroll;
    logic prog;
  } msc_keys_s;
  localparam int unsigned KEY_N = 4;
endpackage

// ---- rtl/msc_edge_det.sv ----
// registered rise and fall pulse detector for a group of synchronous inputs
`timescale 1ns/1ps
module msc_edge_det #(
  parameter int unsigned N = 2
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [N-1:0] i_sig,
  output logic [N-1:0] o_rise,
  output logic [N-1:0] o_fall
);
  if (N < 1) begin : g_chk
    $error("msc_edge_det needs at least one input");
  end

  logic [N-1:0] prev_reg;

  for (genvar g = 0; g < N; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        prev_reg[g] <= 1'b0;
        o_rise[g] <= 1'b0;
        o_fall[g] <= 1'b0;
      end else begin
        prev_reg[g] <= i_sig[g];
        o_rise[g] <= i_sig[g] & ~prev_reg[g];
        o_fall[g] <= ~i_sig[g] & prev_reg[g];
      end
    end
  end
endmodule

// ---- rtl/msc_retx_scale.sv ----
// linear scaling of the displayed value onto the retransmission code, clamped
`timescale 1ns/1ps
module msc_retx_scale #(
  parameter int unsigned VW = 17
) (
  input wire logic [VW-1:0] i_value,
  input wire logic [VW-1:0] i_min,
  input wire logic [VW-1:0] i_max,
  output logic [7:0] o_code
);
  if (VW < 2 || VW > 24) begin : g_chk
    $error("msc_retx_scale width out of range");
  end

  wire logic [VW-1:0] span = i_max - i_min;
  wire logic [VW-1:0] offs = i_value - i_min;
  wire logic [VW+7:0] num = {offs, 8'h00} - {8'h00, offs};
  wire logic [VW+7:0] quo = num / {8'h00, span};
  wire logic below = (i_value <= i_min);
  wire logic above = (i_value >= i_max);

  // below is tested first so a value at or under the minimum always clamps low,
  // even for an inverted span; an empty or inverted span never reaches the divider
  assign o_code = below ? 8'h00 :
                  above ? msc_pkg::RETX_TOP :
                  quo[7:0];
endmodule

// ---- rtl/msc_top.sv ----
// settings, display colour, prompt timing and retransmission control of the rate meter
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - reset key enabled: reset key while rate viewed clears the rate value
// - reset key disabled: key ignored, only remote reset input clears rate
// - retransmission picks none or one of four ranges; scales shown only then
// - scale minimum 0..99999, default 0, maps to bottom of range
// - scale maximum 0..99999, default 100, maps to top of range
// - serial option none or fitted; address and speed shown only when fitted
// - node address 1..99, default 1
// - serial speed 1200, 2400, 4800 or 9600, default 4800, host matches
// - character: one start, seven data, even parity, one stop bit
// - colour red, green, or green to red (default) switching on alarm
// - red then green: red before alarm, green once alarm reached
// - preset lock on: presets read only; off (default): editable
// - help on: name first, value after 3 s idle or at scroll key
// - help off: value only, parameter named by single secondary character
// - control inputs edge sensitive, acted on within 25 ms
// - input one is remote rate reset, input two is security lockout
// - retransmission refreshed every 250 ms with 8 bit resolution
// - alarm active when value at or above high alarm, default 1000
module msc_top #(
  parameter int unsigned HELP_CYCLES = msc_pkg::HELP_CYC,
  parameter int unsigned UPD_CYCLES = msc_pkg::UPD_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire msc_pkg::msc_keys_s i_keys,
  input wire logic [1:0] i_ctl,
  input wire logic i_viewing_rate,
  input wire logic i_param_enter,
  input wire logic [16:0] i_value,
  output logic o_rate_clear,
  output logic o_lockout,
  output logic o_edit_allowed,
  output logic o_display_red,
  output logic o_display_green,
  output logic o_show_name,
  output logic o_single_char_id,
  output logic o_scale_menu,
  output logic o_serial_menu,
  output logic [2:0] o_retx_range,
  output logic [7:0] o_retx_code,
  output logic o_serial_en,
  output logic [6:0] o_node_addr,
  output logic [1:0] o_baud_sel
);
  if (HELP_CYCLES < 2 || HELP_CYCLES >= (1 << msc_pkg::TMR_W) ||
      UPD_CYCLES < 2 || UPD_CYCLES >= (1 << msc_pkg::TMR_W)) begin : g_chk
    $error("msc_top timer counts out of range");
  end

  localparam logic [25:0] HELP_LAST = 26'(HELP_CYCLES - 1);
  localparam logic [25:0] UPD_LAST = 26'(UPD_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // register decode: index 0..4 writable, 5 status, 7 unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == msc_pkg::OFS_CFG) reg_sel = 3'h0;
    else if (a == msc_pkg::OFS_SMIN) reg_sel = 3'h1;
    else if (a == msc_pkg::OFS_SMAX) reg_sel = 3'h2;
    else if (a == msc_pkg::OFS_NODE) reg_sel = 3'h3;
    else if (a == msc_pkg::OFS_HALARM) reg_sel = 3'h4;
    else if (a == msc_pkg::OFS_STATUS) reg_sel = 3'h5;
    else reg_sel = 3'h7;
  endfunction

  msc_pkg::msc_cfg_s cfg_reg;
  logic [16:0] smin_reg, smax_reg, halarm_reg;
  logic [6:0] node_reg;
  logic aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] rd_word;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes
  wire logic aw_hs = i_awvalid & o_awready;
  wire logic w_hs = i_wvalid & o_wready;
  wire logic ar_hs = i_arvalid & o_arready;
  wire logic do_write = aw_have_reg & w_have_reg & ~o_bvalid;
  wire logic aw_have_next = do_write ? 1'b0 : (aw_have_reg | aw_hs);
  wire logic w_have_next = do_write ? 1'b0 : (w_have_reg | w_hs);
  wire logic bvalid_next = do_write | (o_bvalid & ~i_bready);
  wire logic rvalid_next = ar_hs | (o_rvalid & ~i_rready);
  wire logic [2:0] wsel = reg_sel(aw_addr_reg);
  wire logic [2:0] rsel = reg_sel({i_araddr[7:2], 2'b00});
  // partial strobes are refused so a field never ends up half written
  wire logic full_strb = &w_strb_reg;
  wire logic [16:0] wval = w_data_reg[16:0];
  wire logic wval_ok = (w_data_reg[31:17] == 15'h0000) && (wval <= msc_pkg::VAL_MAX);
  wire logic [6:0] wnode = w_data_reg[6:0];
  wire logic wnode_ok = (w_data_reg[31:7] == 25'h0000000) &&
                        (wnode >= msc_pkg::NODE_MIN) && (wnode <= msc_pkg::NODE_MAX);
  wire msc_pkg::msc_cfg_s wcfg = msc_pkg::msc_cfg_s'(w_data_reg[10:0]);
  wire logic wcfg_ok = (wcfg.retx_sel <= msc_pkg::RETX_4_20MA);
  wire logic wr_en = do_write & full_strb;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= msc_pkg::RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= msc_pkg::RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      o_awready <= ~aw_have_next & ~bvalid_next;
      o_wready <= ~w_have_next & ~bvalid_next;
      o_bvalid <= bvalid_next;
      o_arready <= ~rvalid_next;
      o_rvalid <= rvalid_next;
      if (aw_hs) begin
        aw_addr_reg <= {i_awaddr[7:2], 2'b00};
      end
      if (w_hs) begin
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (do_write) begin
        o_bresp <= (wsel > 3'h4) ? msc_pkg::RESP_SLVERR : msc_pkg::RESP_OKAY;
      end
      if (ar_hs) begin
        o_rdata <= rd_word;
        o_rresp <= (rsel == 3'h7) ? msc_pkg::RESP_SLVERR : msc_pkg::RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // settings registers; out-of-range values are ignored and the old one kept
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_reg <= msc_pkg::msc_cfg_s'(msc_pkg::CFG_RST);
      smin_reg <= msc_pkg::SMIN_RST;
      smax_reg <= msc_pkg::SMAX_RST;
      node_reg <= msc_pkg::NODE_RST;
      halarm_reg <= msc_pkg::HALARM_RST;
    end else if (wr_en) begin
      if (wsel == 3'h0 && wcfg_ok) cfg_reg <= wcfg;
      if (wsel == 3'h1 && wval_ok) smin_reg <= wval;
      if (wsel == 3'h2 && wval_ok) smax_reg <= wval;
      if (wsel == 3'h3 && wnode_ok) node_reg <= wnode;
      if (wsel == 3'h4 && wval_ok) halarm_reg <= wval;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detection of keys and control inputs
  logic [msc_pkg::KEY_N-1:0] key_rise;
  logic [1:0] ctl_rise, ctl_fall;

  msc_edge_det #(.N(msc_pkg::KEY_N)) u_key_edge (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sig(i_keys),
    .o_rise(key_rise),
    .o_fall()
  );

  msc_edge_det #(.N(2)) u_ctl_edge (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sig(i_ctl),
    .o_rise(ctl_rise),
    .o_fall(ctl_fall)
  );

  msc_pkg::msc_keys_s key_ev;
  assign key_ev = msc_pkg::msc_keys_s'(key_rise);
  wire logic key_any = |key_rise;

  //////////////////////////////////////////////////////////////////////////////
  // rate clear, lockout, alarm colour
  wire logic front_clear = key_ev.rst & cfg_reg.reset_key_en & i_viewing_rate;
  wire logic rate_clear_next = front_clear | ctl_rise[0];
  // lockout follows the last edge seen on input two
  wire logic lockout_next = ctl_rise[1] ? 1'b1 : (ctl_fall[1] ? 1'b0 : o_lockout);
  wire logic alarm = (i_value >= halarm_reg);
  logic red_next;
  always_comb begin
    case (cfg_reg.colour)
      msc_pkg::COL_RED: red_next = 1'b1;
      msc_pkg::COL_GREEN: red_next = 1'b0;
      msc_pkg::COL_GREEN_TO_RED: red_next = alarm;
      default: red_next = ~alarm;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // help prompt: parameter name first, then value
  msc_pkg::msc_prompt_e pr_reg, pr_next;
  logic [25:0] help_tmr_reg, help_tmr_next;
  always_comb begin
    pr_next = pr_reg;
    help_tmr_next = help_tmr_reg;
    if (i_param_enter) begin
      pr_next = cfg_reg.prompt_text_setting ? msc_pkg::PR_NAME : msc_pkg::PR_VALUE;
      help_tmr_next = 26'h0000000;
    end else begin
      case (pr_reg)
        msc_pkg::PR_NAME: begin
          if (!cfg_reg.prompt_text_setting || key_ev.scroll || help_tmr_reg == HELP_LAST) begin
            pr_next = msc_pkg::PR_VALUE;
          end else if (key_any) begin
            help_tmr_next = 26'h0000000;
          end else begin
            help_tmr_next = help_tmr_reg + 26'h0000001;
          end
        end
        default: pr_next = msc_pkg::PR_VALUE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // retransmission refresh every update period
  logic [25:0] upd_tmr_reg;
  logic upd_tick_reg;
  logic [7:0] scaled;
  msc_retx_scale #(.VW(msc_pkg::VAL_W)) u_scale (
    .i_value(i_value),
    .i_min(smin_reg),
    .i_max(smax_reg),
    .o_code(scaled)
  );
  wire logic retx_on = (cfg_reg.retx_sel != msc_pkg::RETX_NONE);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      upd_tmr_reg <= 26'h0000000;
      upd_tick_reg <= 1'b0;
      o_retx_code <= 8'h00;
      pr_reg <= msc_pkg::PR_VALUE;
      help_tmr_reg <= 26'h0000000;
    end else begin
      upd_tick_reg <= (upd_tmr_reg == UPD_LAST);
      upd_tmr_reg <= (upd_tmr_reg == UPD_LAST) ? 26'h0000000 : upd_tmr_reg + 26'h0000001;
      if (upd_tick_reg) o_retx_code <= retx_on ? scaled : 8'h00;
      pr_reg <= pr_next;
      help_tmr_reg <= help_tmr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rate_clear <= 1'b0;
      o_lockout <= 1'b0;
      o_edit_allowed <= 1'b0;
      o_display_red <= 1'b0;
      o_display_green <= 1'b0;
      o_show_name <= 1'b0;
      o_single_char_id <= 1'b0;
      o_scale_menu <= 1'b0;
      o_serial_menu <= 1'b0;
      o_retx_range <= 3'h0;
      o_serial_en <= 1'b0;
      o_node_addr <= msc_pkg::NODE_RST;
      o_baud_sel <= 2'h0;
    end else begin
      o_rate_clear <= rate_clear_next;
      o_lockout <= lockout_next;
      o_edit_allowed <= ~cfg_reg.preset_lock & ~lockout_next;
      o_display_red <= red_next;
      o_display_green <= ~red_next;
      o_show_name <= (pr_next == msc_pkg::PR_NAME);
      o_single_char_id <= ~cfg_reg.prompt_text_setting;
      o_scale_menu <= retx_on;
      o_serial_menu <= cfg_reg.serial_fitted;
      o_retx_range <= cfg_reg.retx_sel;
      o_serial_en <= cfg_reg.serial_fitted;
      o_node_addr <= node_reg;
      o_baud_sel <= cfg_reg.baud;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; the status word also reports the fixed character format
  always_comb begin
    rd_word = 32'h00000000;
    if (rsel == 3'h0) rd_word[10:0] = cfg_reg;
    else if (rsel == 3'h1) rd_word[16:0] = smin_reg;
    else if (rsel == 3'h2) rd_word[16:0] = smax_reg;
    else if (rsel == 3'h3) rd_word[6:0] = node_reg;
    else if (rsel == 3'h4) rd_word[16:0] = halarm_reg;
    else if (rsel == 3'h5) begin
      rd_word[7:0] = {1'b0, o_serial_menu, o_scale_menu, ~o_show_name, o_lockout,
                      o_display_green, o_display_red, alarm};
      rd_word[15:8] = o_retx_code;
      rd_word[20:16] = {msc_pkg::FMT_STOP_BITS, msc_pkg::FMT_PARITY_EVEN,
                        msc_pkg::FMT_DATA_BITS};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_front_clear;
    @(posedge i_clk) disable iff (!i_nrst)
    (key_ev.rst && cfg_reg.reset_key_en && i_viewing_rate) |=> o_rate_clear;
  endproperty
  a_front_clear: assert property (p_front_clear) else $error("front reset lost");
  property p_key_ignored;
    @(posedge i_clk) disable iff (!i_nrst)
    (key_ev.rst && !cfg_reg.reset_key_en && !ctl_rise[0]) |=> !o_rate_clear;
  endproperty
  a_key_ignored: assert property (p_key_ignored) else $error("disabled key cleared");
  property p_remote_clear;
    @(posedge i_clk) disable iff (!i_nrst)
    $rose(i_ctl[0]) |-> ##[1:3] o_rate_clear;
  endproperty
  a_remote_clear: assert property (p_remote_clear) else $error("remote reset late");
  property p_lockout;
    @(posedge i_clk) disable iff (!i_nrst)
    $rose(i_ctl[1]) |-> ##2 (o_lockout && !o_edit_allowed);
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not taken");
  property p_g2r;
    @(posedge i_clk) disable iff (!i_nrst)
    (cfg_reg.colour == msc_pkg::COL_GREEN_TO_RED) |=> (o_display_red == $past(alarm));
  endproperty
  a_g2r: assert property (p_g2r) else $error("green to red colour wrong");
  property p_r2g;
    @(posedge i_clk) disable iff (!i_nrst)
    (cfg_reg.colour == msc_pkg::COL_RED_THEN_GREEN && alarm) |=> o_display_green;
  endproperty
  a_r2g: assert property (p_r2g) else $error("red then green colour wrong");
  property p_alarm;
    @(posedge i_clk) disable iff (!i_nrst)
    (cfg_reg.colour == msc_pkg::COL_GREEN_TO_RED && i_value >= halarm_reg) |=>
      (o_display_red && !o_display_green);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not at threshold");
  property p_lock;
    @(posedge i_clk) disable iff (!i_nrst)
    cfg_reg.preset_lock |=> !o_edit_allowed;
  endproperty
  a_lock: assert property (p_lock) else $error("locked presets editable");
  property p_scroll;
    @(posedge i_clk) disable iff (!i_nrst)
    (pr_reg == msc_pkg::PR_NAME && key_ev.scroll && !i_param_enter) |=> !o_show_name;
  endproperty
  a_scroll: assert property (p_scroll) else $error("scroll did not show value");
  property p_help_off;
    @(posedge i_clk) disable iff (!i_nrst)
    !cfg_reg.prompt_text_setting |=> (!o_show_name && o_single_char_id);
  endproperty
  a_help_off: assert property (p_help_off) else $error("name shown with help off");
  property p_node;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_node_addr >= msc_pkg::NODE_MIN) && (o_node_addr <= msc_pkg::NODE_MAX);
  endproperty
  a_node: assert property (p_node) else $error("node address out of range");
  property p_refresh;
    @(posedge i_clk) disable iff (!i_nrst)
    (upd_tick_reg && retx_on) |=> (o_retx_code == $past(scaled));
  endproperty
  a_refresh: assert property (p_refresh) else $error("retransmission not refreshed");
  property p_clamp;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_value <= smin_reg) |-> (scaled == 8'h00);
  endproperty
  a_clamp: assert property (p_clamp) else $error("low clamp failed");
  property p_menus;
    @(posedge i_clk) disable iff (!i_nrst)
    1'b1 |=> (o_scale_menu == $past(retx_on)) && (o_serial_menu == $past(cfg_reg.serial_fitted));
  endproperty
  a_menus: assert property (p_menus) else $error("menu visibility wrong");
endmodule

// ---- tb/msc_panel_model.sv ----
// front panel operator model: key presses and control input levels
`timescale 1ns/1ps
module msc_panel_model (
  input wire logic i_clk,
  output msc_pkg::msc_keys_s o_keys,
  output logic [1:0] o_ctl
);
  initial begin
    o_keys = '0;
    o_ctl = 2'h0;
  end
  // a press is held three cycles so the edge detector sees one clean rise
  task automatic press(input int k);
    @(posedge i_clk);
    o_keys[k] <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_keys[k] <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic ctl(input int k, input logic v);
    @(posedge i_clk);
    o_ctl[k] <= v;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

// ---- tb/meter_settings_control_tb.sv ----
// self-checking bench of the meter settings control block
`timescale 1ns/1ps
module meter_settings_control_tb;
  logic clk, nrst, awv, wv, bry, arv, rry, view, pen, awr, wrd, bv, arr, rv;
  logic clr, lock, edit, red, grn, name, sid, smenu, sermenu, sen;
  logic [7:0] awa, ara, code;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] br, rr, baud, ctl;
  logic [16:0] val;
  logic [2:0] rng;
  logic [6:0] node;
  msc_pkg::msc_keys_s keys;
  int n_fail, comparisons, nclr;
  msc_panel_model u_panel (.i_clk(clk), .o_keys(keys), .o_ctl(ctl));
  msc_top #(.HELP_CYCLES(20), .UPD_CYCLES(16)) u_dut (.i_clk(clk), .i_nrst(nrst),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd),
    .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv), .i_bready(bry), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rry),
    .o_rdata(rd), .o_rresp(rr), .i_keys(keys), .i_ctl(ctl), .i_viewing_rate(view),
    .i_param_enter(pen), .i_value(val), .o_rate_clear(clr), .o_lockout(lock),
    .o_edit_allowed(edit), .o_display_red(red), .o_display_green(grn), .o_show_name(name),
    .o_single_char_id(sid), .o_scale_menu(smenu), .o_serial_menu(sermenu),
    .o_retx_range(rng), .o_retx_code(code), .o_serial_en(sen), .o_node_addr(node),
    .o_baud_sel(baud));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (clr === 1'b1) nclr <= nclr + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= 4'hF; bry <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awr === 1'b1) begin ta = 1; awv <= 1'b0; end
      if (!tw && wrd === 1'b1) begin tw = 1; wv <= 1'b0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", 32'h0, {30'h0, br});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    rry <= 1'b0;
    chk("rdata", e, rd);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rdc(8'h00, 32'h541, 2'h0);
    rdc(8'h08, 32'h64, 2'h0);
    rdc(8'h10, 32'h3E8, 2'h0);
    rdc(8'h20, 32'h0, 2'h2);
    chk("baud", 32'h2, {30'h0, baud});
    chk("sermenu", 32'h0, {30'h0, sermenu, sen});
    rdc(8'h14, 32'h001F0014, 2'h0);
    chk("fmt", 32'h1F, {27'h0, rd[20:16]});
  endtask
  task automatic t_reset_key;
    u_panel.press(3);
    chk("clr_on", 32'h1, nclr);
    view <= 1'b0;
    u_panel.press(3);
    chk("clr_hidden", 32'h1, nclr);
    view <= 1'b1;
    wr(8'h00, 32'h540);
    u_panel.press(3);
    chk("clr_off", 32'h1, nclr);
    u_panel.ctl(0, 1'b1);
    chk("clr_remote", 32'h2, nclr);
  endtask
  task automatic t_colour;
    val <= 17'd999; cyc(3);
    chk("g2r_low", 32'h2, {30'h0, grn, red});
    val <= 17'd1000; cyc(3);
    chk("g2r_alarm", 32'h1, {30'h0, grn, red});
    wr(8'h00, 32'h5C0); cyc(2);
    chk("r2g_alarm", 32'h2, {30'h0, grn, red});
    val <= 17'd999; cyc(3);
    chk("r2g_low", 32'h1, {30'h0, grn, red});
  endtask
  task automatic t_retx;
    wr(8'h00, 32'h548); val <= 17'd50; cyc(20);
    chk("range", 32'h4, {29'h0, rng});
    chk("smenu", 32'h1, {31'h0, smenu});
    chk("code_mid", 32'h7F, {24'h0, code});
    val <= 17'd200; cyc(20);
    chk("code_top", 32'hFF, {24'h0, code});
    wr(8'h04, 32'h64); wr(8'h08, 32'h1869F); val <= 17'd99; cyc(20);
    chk("code_bot", 32'h0, {24'h0, code});
  endtask
  task automatic t_serial;
    wr(8'h00, 32'h770); wr(8'h0C, 32'h63); wr(8'h0C, 32'h64); cyc(2);
    chk("sermenu", 32'h3, {30'h0, sermenu, sen});
    chk("node", 32'h63, {25'h0, node});
    chk("baud", 32'h3, {30'h0, baud});
  endtask
  task automatic t_edit;
    wr(8'h00, 32'h540); cyc(2);
    u_panel.ctl(1, 1'b1);
    chk("lock", 32'h2, {30'h0, lock, edit});
    u_panel.ctl(1, 1'b0);
    chk("unlock", 32'h1, {30'h0, lock, edit});
    wr(8'h00, 32'h740); cyc(2);
    chk("preset", 32'h0, {31'h0, edit});
  endtask
  task automatic t_help;
    pen <= 1'b1; cyc(1); pen <= 1'b0; cyc(2);
    chk("name", 32'h1, {31'h0, name});
    u_panel.press(1);
    chk("scroll", 32'h0, {31'h0, name});
    pen <= 1'b1; cyc(1); pen <= 1'b0; cyc(30);
    chk("idle", 32'h0, {31'h0, name});
    wr(8'h00, 32'h340); pen <= 1'b1; cyc(1); pen <= 1'b0; cyc(2);
    chk("sid", 32'h1, {30'h0, name, sid});
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {nrst, awv, wv, bry, arv, rry, pen} = '0;
    {awa, ara, wd, ws} = '0;
    view = 1'b1;
    val = 17'h0;
    n_fail = 0;
    comparisons = 0;
    nclr = 0;
    cyc(5);
    nrst <= 1'b1;
    cyc(2);
    t_defaults();
    t_reset_key();
    t_colour();
    t_retx();
    t_serial();
    t_edit();
    t_help();
    report_and_stop();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule
